// [logic/tif_pkg.sv]
// package: register map, bit positions and carriers for the timer flag block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package tif_pkg;

   // register byte offsets on the bus
   localparam logic [7:0] OFS_FLAGS     = 8'h00;
   localparam logic [7:0] OFS_EXT_FLAGS = 8'h04;
   localparam logic [7:0] OFS_MASK      = 8'h08;
   localparam logic [7:0] OFS_EXT_MASK  = 8'h0c;
   localparam logic [7:0] OFS_MODE      = 8'h10;
   localparam logic [7:0] OFS_STATUS    = 8'h14;

   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam logic [7:0] RST_MASK  = 8'h00;
   localparam logic [3:0] RST_MODE  = 4'h0;

   // unit-1 bit positions in flag and mask registers
   localparam int U1_OVF_BIT = 7;
   localparam int U1_CMPA_BIT = 6;
   localparam int U1_CMPB_BIT = 5;
   localparam int U1_CAP_BIT = 3;
   // unit-3 bit positions in the extended registers
   localparam int U3_CAP_BIT = 5;
   localparam int U3_CMPA_BIT = 4;
   localparam int U3_CMPB_BIT = 3;
   localparam int U3_OVF_BIT = 2;

   // mode register: unit-1 field at [3:0], unit-3 field at [7:4]
   localparam int MODE_U1_LSB = 0;
   localparam int MODE_U3_LSB = 4;

   // waveform modes with overflow at max; 0 normal, 4 and 12 clear on compare
   localparam logic [3:0] WGM_NORMAL   = 4'h0;
   localparam logic [3:0] WGM_CTC_CMPA = 4'h4;
   localparam logic [3:0] WGM_CTC_CAP  = 4'hc;
   // modes in which the capture value is the counter top
   localparam logic [3:0] WGM_PWM_CAP_PC  = 4'h8;
   localparam logic [3:0] WGM_PWM_CAP_PFC = 4'h8;
   localparam logic [3:0] WGM_PWM_CAP_PFC2 = 4'ha;
   localparam logic [3:0] WGM_PWM_CAP_FAST = 4'he;

   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

   // per-unit events from the counter logic, one core cycle each
   typedef struct packed {
      logic overflow;
      logic at_top;
      logic at_bottom;
      logic cmp_a_match;
      logic cmp_b_match;
      logic force_cmp_a;
      logic force_cmp_b;
      logic capture_pin;
      logic timer_tick;
   } tif_unit_ev_t;

   // per-unit vector acknowledges from the core
   typedef struct packed {
      logic overflow;
      logic cmp_a;
      logic cmp_b;
      logic capture;
   } tif_unit_ack_t;

   typedef enum logic [1:0] {
      TIF_IDLE  = 2'b01,
      TIF_WRITE = 2'b10
   } tif_bus_state_t;

endpackage

// [logic/tif_unit.sv]
// one timer unit's four event flags with set, acknowledge and write-one clear
`timescale 1ns/1ps
module tif_unit (
   input  wire logic                   sys_clk_i,
   input  wire logic                   nrst_i,
   input  wire tif_pkg::tif_unit_ev_t  ev_i,
   input  wire tif_pkg::tif_unit_ack_t ack_i,
   input  wire tif_pkg::tif_unit_ack_t w1c_i,
   input  wire logic [3:0]             mode_i,
   output tif_pkg::tif_unit_ack_t      flags_o
);

   tif_pkg::tif_unit_ack_t next_flags;
   tif_pkg::tif_unit_ack_t set_ev;
   tif_pkg::tif_unit_ack_t clr_ev;
   logic                   match_a_seen;
   logic                   match_b_seen;
   logic                   cap_is_top;
   logic                   ovf_at_max;

   // ----------------------------------------------------------------------
   // match held until the next timer tick, then the flag is set
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         match_a_seen <= 1'b0;
         match_b_seen <= 1'b0;
      end else begin
         // force strobes arrive on ev_i but are ignored here, so they never set flags
         if (ev_i.cmp_a_match) begin
            match_a_seen <= 1'b1;
         end else if (ev_i.timer_tick) begin
            match_a_seen <= 1'b0;
         end
         if (ev_i.cmp_b_match) begin
            match_b_seen <= 1'b1;
         end else if (ev_i.timer_tick) begin
            match_b_seen <= 1'b0;
         end
      end
   end

   always_comb begin
      ovf_at_max = (mode_i == tif_pkg::WGM_NORMAL) || (mode_i == tif_pkg::WGM_CTC_CMPA)
                   || (mode_i == tif_pkg::WGM_CTC_CAP);
      cap_is_top = (mode_i == tif_pkg::WGM_PWM_CAP_PC) || (mode_i == tif_pkg::WGM_PWM_CAP_PFC2)
                   || (mode_i == tif_pkg::WGM_CTC_CAP) || (mode_i == tif_pkg::WGM_PWM_CAP_FAST);
      // normal/clear-on-compare: at overflow; PWM modes: at top or bottom
      set_ev.overflow = ovf_at_max ? ev_i.overflow
                      : (mode_i[0] && mode_i[1] && mode_i[2]) ? ev_i.at_top
                      : (mode_i inside {4'h5, 4'h6, 4'h7, 4'he}) ? ev_i.at_top
                      : ev_i.at_bottom;
      set_ev.cmp_a = match_a_seen && ev_i.timer_tick;
      set_ev.cmp_b = match_b_seen && ev_i.timer_tick;
      // capture register as top: flag tracks top instead of the pin
      set_ev.capture = cap_is_top ? ev_i.at_top : ev_i.capture_pin;
      clr_ev = ack_i | w1c_i;
      next_flags = set_ev | (flags_o & ~clr_ev);
   end

   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         flags_o <= '0;
      end else begin
         flags_o <= next_flags;
      end
   end

endmodule

// [logic/tif_top.sv]
// timer interrupt flag and enable block with an AHB-Lite register slave
//
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module tif_top (
   input  wire logic                   sys_clk_i,
   input  wire logic                   nrst_i,
   // ahb-lite slave
   input  wire logic                   hsel_i,
   input  wire logic [7:0]             haddr_i,
   input  wire logic [1:0]             htrans_i,
   input  wire logic                   hwrite_i,
   input  wire logic [2:0]             hsize_i,
   input  wire logic [31:0]            hwdata_i,
   input  wire logic                   hready_i,
   output logic      [31:0]            hrdata_o,
   output logic                        hreadyout_o,
   output logic                        hresp_o,
   // timer events and core interface
   input  wire tif_pkg::tif_unit_ev_t  unit1_ev_i,
   input  wire tif_pkg::tif_unit_ev_t  unit3_ev_i,
   input  wire tif_pkg::tif_unit_ack_t unit1_ack_i,
   input  wire tif_pkg::tif_unit_ack_t unit3_ack_i,
   input  wire logic                   global_irq_enable_i,
   output tif_pkg::tif_unit_ack_t      unit1_irq_o,
   output tif_pkg::tif_unit_ack_t      unit3_irq_o
);

   tif_pkg::tif_bus_state_t state;
   logic [7:0]              wr_addr;
   logic [7:0]              timer_irq_mask;
   logic [7:0]              extended_timer_irq_mask;
   logic [7:0]              mode_reg;
   tif_pkg::tif_unit_ack_t  u1_flags;
   tif_pkg::tif_unit_ack_t  u3_flags;
   tif_pkg::tif_unit_ack_t  u1_w1c;
   tif_pkg::tif_unit_ack_t  u3_w1c;
   logic [7:0]              timer_event_flags;
   logic [7:0]              extended_timer_event_flags;
   logic                    addr_phase;
   logic                    wr_now;

   // pack unit-1 flags into their register positions
   function automatic logic [7:0] pack_u1(input tif_pkg::tif_unit_ack_t f);
      logic [7:0] r;
      r = 8'h00;
      r[tif_pkg::U1_OVF_BIT]  = f.overflow;
      r[tif_pkg::U1_CMPA_BIT] = f.cmp_a;
      r[tif_pkg::U1_CMPB_BIT] = f.cmp_b;
      r[tif_pkg::U1_CAP_BIT]  = f.capture;
      return r;
   endfunction

   function automatic logic [7:0] pack_u3(input tif_pkg::tif_unit_ack_t f);
      logic [7:0] r;
      r = 8'h00;
      r[tif_pkg::U3_OVF_BIT]  = f.overflow;
      r[tif_pkg::U3_CMPA_BIT] = f.cmp_a;
      r[tif_pkg::U3_CMPB_BIT] = f.cmp_b;
      r[tif_pkg::U3_CAP_BIT]  = f.capture;
      return r;
   endfunction

   function automatic tif_pkg::tif_unit_ack_t unpack_u1(input logic [7:0] r);
      tif_pkg::tif_unit_ack_t f;
      f.overflow = r[tif_pkg::U1_OVF_BIT];
      f.cmp_a    = r[tif_pkg::U1_CMPA_BIT];
      f.cmp_b    = r[tif_pkg::U1_CMPB_BIT];
      f.capture  = r[tif_pkg::U1_CAP_BIT];
      return f;
   endfunction

   function automatic tif_pkg::tif_unit_ack_t unpack_u3(input logic [7:0] r);
      tif_pkg::tif_unit_ack_t f;
      f.overflow = r[tif_pkg::U3_OVF_BIT];
      f.cmp_a    = r[tif_pkg::U3_CMPA_BIT];
      f.cmp_b    = r[tif_pkg::U3_CMPB_BIT];
      f.capture  = r[tif_pkg::U3_CAP_BIT];
      return f;
   endfunction

   // ----------------------------------------------------------------------
   // bus slave: zero wait states, always OKAY
   // ----------------------------------------------------------------------
   assign addr_phase = hsel_i && hready_i && (htrans_i == tif_pkg::HTRANS_NONSEQ);
   assign wr_now = (state == tif_pkg::TIF_WRITE);

   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         state   <= tif_pkg::TIF_IDLE;
         wr_addr <= 8'h00;
      end else begin
         case (state)
            tif_pkg::TIF_IDLE: begin
               if (addr_phase && hwrite_i) begin
                  state   <= tif_pkg::TIF_WRITE;
                  wr_addr <= haddr_i;
               end
            end
            tif_pkg::TIF_WRITE: begin
               if (addr_phase && hwrite_i) begin
                  wr_addr <= haddr_i;
               end else begin
                  state <= tif_pkg::TIF_IDLE;
               end
            end
            default: begin
               state <= tif_pkg::TIF_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         hreadyout_o <= 1'b0;
         hresp_o     <= 1'b0;
      end else begin
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end
   end

   // read data registered at the address phase; stands in the data phase
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         hrdata_o <= 32'h0000_0000;
      end else if (addr_phase && !hwrite_i) begin
         case (haddr_i)
            tif_pkg::OFS_FLAGS:     hrdata_o <= {24'h00_0000, timer_event_flags};
            tif_pkg::OFS_EXT_FLAGS: hrdata_o <= {24'h00_0000, extended_timer_event_flags};
            tif_pkg::OFS_MASK:      hrdata_o <= {24'h00_0000, timer_irq_mask};
            tif_pkg::OFS_EXT_MASK:  hrdata_o <= {24'h00_0000, extended_timer_irq_mask};
            tif_pkg::OFS_MODE:      hrdata_o <= {24'h00_0000, mode_reg};
            tif_pkg::OFS_STATUS:    hrdata_o <= {31'h0000_0000, global_irq_enable_i};
            default:                hrdata_o <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // mask and mode registers
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         timer_irq_mask          <= tif_pkg::RST_MASK;
         extended_timer_irq_mask <= tif_pkg::RST_MASK;
         mode_reg                <= {tif_pkg::RST_MODE, tif_pkg::RST_MODE};
      end else if (wr_now) begin
         case (wr_addr)
            tif_pkg::OFS_MASK:     timer_irq_mask <= hwdata_i[7:0];
            tif_pkg::OFS_EXT_MASK: extended_timer_irq_mask <= hwdata_i[7:0];
            tif_pkg::OFS_MODE:     mode_reg <= hwdata_i[7:0];
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // flags: write one clears, zero bits leave the flag alone
   // ----------------------------------------------------------------------
   always_comb begin
      u1_w1c = '0;
      u3_w1c = '0;
      if (wr_now && wr_addr == tif_pkg::OFS_FLAGS) begin
         u1_w1c = unpack_u1(hwdata_i[7:0]);
      end
      if (wr_now && wr_addr == tif_pkg::OFS_EXT_FLAGS) begin
         u3_w1c = unpack_u3(hwdata_i[7:0]);
      end
   end

   tif_unit u_unit1 (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .ev_i      (unit1_ev_i),
      .ack_i     (unit1_ack_i),
      .w1c_i     (u1_w1c),
      .mode_i    (mode_reg[tif_pkg::MODE_U1_LSB +: 4]),
      .flags_o   (u1_flags)
   );

   tif_unit u_unit3 (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .ev_i      (unit3_ev_i),
      .ack_i     (unit3_ack_i),
      .w1c_i     (u3_w1c),
      .mode_i    (mode_reg[tif_pkg::MODE_U3_LSB +: 4]),
      .flags_o   (u3_flags)
   );

   assign timer_event_flags          = pack_u1(u1_flags);
   assign extended_timer_event_flags = pack_u3(u3_flags);

   // ----------------------------------------------------------------------
   // requests registered; one cycle after the flag sets
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         unit1_irq_o <= '0;
         unit3_irq_o <= '0;
      end else begin
         unit1_irq_o.overflow <= global_irq_enable_i
            && timer_irq_mask[tif_pkg::U1_OVF_BIT] && u1_flags.overflow;
         unit1_irq_o.cmp_a <= global_irq_enable_i
            && timer_irq_mask[tif_pkg::U1_CMPA_BIT] && u1_flags.cmp_a;
         unit1_irq_o.cmp_b <= global_irq_enable_i
            && timer_irq_mask[tif_pkg::U1_CMPB_BIT] && u1_flags.cmp_b;
         unit1_irq_o.capture <= global_irq_enable_i
            && timer_irq_mask[tif_pkg::U1_CAP_BIT] && u1_flags.capture;
         unit3_irq_o.capture <= global_irq_enable_i
            && extended_timer_irq_mask[tif_pkg::U3_CAP_BIT] && u3_flags.capture;
         unit3_irq_o.cmp_a <= global_irq_enable_i
            && extended_timer_irq_mask[tif_pkg::U3_CMPA_BIT] && u3_flags.cmp_a;
         unit3_irq_o.cmp_b <= global_irq_enable_i
            && extended_timer_irq_mask[tif_pkg::U3_CMPB_BIT] && u3_flags.cmp_b;
         unit3_irq_o.overflow <= global_irq_enable_i
            && extended_timer_irq_mask[tif_pkg::U3_OVF_BIT] && u3_flags.overflow;
      end
   end

endmodule

// [verif/tif_properties.sv]
// checker: request gating and flag-to-request timing seen at the block's ports
`timescale 1ns/1ps
module tif_props (
   input wire logic                   sys_clk_i,
   input wire logic                   nrst_i,
   input wire logic                   hsel_i,
   input wire logic [7:0]             haddr_i,
   input wire logic [1:0]             htrans_i,
   input wire logic                   hwrite_i,
   input wire logic [31:0]            hwdata_i,
   input wire logic                   hready_i,
   input wire logic                   hreadyout_o,
   input wire logic                   hresp_o,
   input wire tif_pkg::tif_unit_ev_t  unit1_ev_i,
   input wire tif_pkg::tif_unit_ev_t  unit3_ev_i,
   input wire tif_pkg::tif_unit_ack_t unit1_ack_i,
   input wire logic                   global_irq_enable_i,
   input wire tif_pkg::tif_unit_ack_t unit1_irq_o,
   input wire tif_pkg::tif_unit_ack_t unit3_irq_o
);
   // ---------------------------------------------------------------
   // register mirror
   // ---------------------------------------------------------------
   // masks and modes are internal, so follow them from bus writes
   logic [7:0] mir [0:7];
   logic       wpend;
   logic [2:0] widx;
   wire  [3:0] m1 = {mir[2][7], mir[2][6], mir[2][5], mir[2][3]};
   wire  [3:0] m3 = {mir[3][2], mir[3][4], mir[3][3], mir[3][5]};
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         wpend <= 1'b0;
         widx  <= 3'h0;
      end else begin
         wpend <= hsel_i && hready_i && htrans_i == tif_pkg::HTRANS_NONSEQ && hwrite_i;
         widx  <= haddr_i[4:2];
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) mir <= '{default: 8'h00};
      else if (wpend) mir[widx] <= hwdata_i[7:0];
   end
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   a_glob_gate: assert property (
      !global_irq_enable_i |=> unit1_irq_o == 4'h0 && unit3_irq_o == 4'h0)
      else $error("request raised with interrupts globally off");
   a_u1_mask: assert property ((4'(unit1_irq_o) & ~$past(m1)) == 4'h0)
      else $error("unit1 request without its mask bit");
   a_u3_mask: assert property ((4'(unit3_irq_o) & ~$past(m3)) == 4'h0)
      else $error("unit3 request without its mask bit");
   a_u1_ack_clear: assert property (
      unit1_ack_i.overflow && !unit1_ev_i.overflow && !unit1_ev_i.at_top
      && !unit1_ev_i.at_bottom |-> ##2 !unit1_irq_o.overflow)
      else $error("unit1 overflow request survived its acknowledge");
   a_u1_ovf_req: assert property (
      unit1_ev_i.overflow && mir[4][3:0] inside {4'h0, 4'h4, 4'hc}
      ##1 (global_irq_enable_i && mir[2][7]) |=> unit1_irq_o.overflow)
      else $error("unit1 overflow request missing");
   a_u1_cmpb_req: assert property (
      unit1_ev_i.cmp_b_match ##1 unit1_ev_i.timer_tick
      ##1 (global_irq_enable_i && mir[2][5]) |=> unit1_irq_o.cmp_b)
      else $error("unit1 compare b request missing");
   a_u3_cap_req: assert property (
      unit3_ev_i.capture_pin && !(mir[4][7:4] inside {4'h8, 4'ha, 4'hc, 4'he})
      ##1 (global_irq_enable_i && mir[3][5]) |=> unit3_irq_o.capture)
      else $error("unit3 capture request missing");
   a_bus_okay: assert property ($past(nrst_i) |-> hreadyout_o && !hresp_o)
      else $error("bus slave not ready or not okay");
endmodule

// [verif/tif_core_model.sv]
// processor core stand-in: enters one pending vector at a time and pulses its acknowledge
`timescale 1ns/1ps
module tif_core_model (
   input  wire logic                   sys_clk_i,
   input  wire logic                   nrst_i,
   input  wire logic                   run_i,
   input  wire logic [3:0]             lat_i,
   input  wire tif_pkg::tif_unit_ack_t irq1_i,
   input  wire tif_pkg::tif_unit_ack_t irq3_i,
   output tif_pkg::tif_unit_ack_t      ack1_o,
   output tif_pkg::tif_unit_ack_t      ack3_o
);
   logic [3:0] cnt;
   logic [1:0] hold;
   // ---------------------------------------------------------------
   // vector entry
   // ---------------------------------------------------------------
   // a request drops two cycles after its acknowledge: hold off so it is not taken twice
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         cnt    <= 4'h0;
         hold   <= 2'h0;
         ack1_o <= '0;
         ack3_o <= '0;
      end else begin
         ack1_o <= '0;
         ack3_o <= '0;
         if (hold != 2'h0) begin
            hold <= hold - 2'h1;
         end else if (run_i && (irq1_i != '0 || irq3_i != '0)) begin
            cnt <= cnt + 4'h1;
            if (cnt >= lat_i) begin
               cnt  <= 4'h0;
               hold <= 2'h3;
               if (irq1_i != '0)
                  ack1_o <= 4'(irq1_i) & (~4'(irq1_i) + 4'h1);
               else
                  ack3_o <= 4'(irq3_i) & (~4'(irq3_i) + 4'h1);
            end
         end else begin
            cnt <= 4'h0;
         end
      end
   end
endmodule

// [verif/tb.sv]
// testbench: flag events, register access, gating and vector acknowledge
`timescale 1ns/1ps
module tb;
   // ---------------------------------------------------------------
   // stimulus and wiring
   // ---------------------------------------------------------------
   localparam logic [8:0] OVF = 9'h100, TOP = 9'h080, MA = 9'h020, MB = 9'h010, FA = 9'h008,
                          FB = 9'h004, CAP = 9'h002, TK = 9'h001, BOT = 9'h040;
   typedef struct packed {
      logic       u3;
      logic [8:0] e0;
      logic [8:0] e1;
      logic [7:0] flag;
      logic [3:0] irq;
   } tif_row_t;
   localparam tif_row_t ROWS [8] = '{
      '{1'b0, OVF, 9'h0, 8'h80, 4'h8}, '{1'b0, MA, TK, 8'h40, 4'h4},
      '{1'b0, MB, TK, 8'h20, 4'h2}, '{1'b0, CAP, 9'h0, 8'h08, 4'h1},
      '{1'b1, CAP, 9'h0, 8'h20, 4'h1}, '{1'b1, MA, TK, 8'h10, 4'h4},
      '{1'b1, MB, TK, 8'h08, 4'h2}, '{1'b1, OVF, 9'h0, 8'h04, 4'h8}};
   logic                   sys_clk = 1'b0;
   logic                   nrst = 1'b0;
   logic [7:0]             haddr = 8'h00;
   logic [1:0]             htrans = 2'b00;
   logic                   hwrite = 1'b0;
   logic [31:0]            hwdata = 32'h0;
   logic                   glob = 1'b0;
   logic                   run = 1'b0;
   logic [3:0]             lat = 4'h0;
   tif_pkg::tif_unit_ev_t  ev1 = '0;
   tif_pkg::tif_unit_ev_t  ev3 = '0;
   tif_pkg::tif_unit_ack_t ack1, ack3, irq1, irq3;
   logic [31:0]            hrdata;
   logic                   hready, hresp;
   int                     n_mismatch = 0;
   int                     tests_run = 0;
   always #5 sys_clk = ~sys_clk;
   tif_top DUT (.sys_clk_i(sys_clk), .nrst_i(nrst), .hsel_i(1'b1), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .unit1_ev_i(ev1), .unit3_ev_i(ev3), .unit1_ack_i(ack1), .unit3_ack_i(ack3),
      .global_irq_enable_i(glob), .unit1_irq_o(irq1), .unit3_irq_o(irq3));
   tif_core_model u_core (.sys_clk_i(sys_clk), .nrst_i(nrst), .run_i(run), .lat_i(lat),
      .irq1_i(irq1), .irq3_i(irq3), .ack1_o(ack1), .ack3_o(ack3));
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
      int n;
      n = 0;
      haddr <= a;
      hwrite <= w;
      htrans <= tif_pkg::HTRANS_NONSEQ;
      do @(posedge sys_clk); while (hready !== 1'b1 && ++n < 20);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge sys_clk); while (hready !== 1'b1 && ++n < 20);
      r = hrdata;
      if (n >= 20) n_mismatch++;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(a, 1'b1, d, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(a, 1'b0, 32'h0, r);
      check(r, exp);
   endtask
   // two event cycles on one unit, then time for flag and request to settle
   task automatic pulse(input logic u3, input logic [8:0] e0, input logic [8:0] e1);
      if (u3) ev3 <= e0;
      else ev1 <= e0;
      @(posedge sys_clk);
      if (u3) ev3 <= e1;
      else ev1 <= e1;
      @(posedge sys_clk);
      ev1 <= '0;
      ev3 <= '0;
      repeat (2) @(posedge sys_clk);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      logic [7:0] a;
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      glob <= 1'b1;
      wr(8'h08, 32'hff);
      wr(8'h0c, 32'hff);
      rd(8'h08, 32'hff);
      foreach (ROWS[i]) begin
         a = ROWS[i].u3 ? 8'h04 : 8'h00;
         pulse(ROWS[i].u3, ROWS[i].e0, ROWS[i].e1);
         check(32'({irq1, irq3}), 32'(ROWS[i].u3 ? {4'h0, ROWS[i].irq} : {ROWS[i].irq, 4'h0}));
         wr(a, 32'h0);
         rd(a, 32'(ROWS[i].flag));
         wr(a, 32'(ROWS[i].flag));
         rd(a, 32'h0);
         $display("row %0d done", i);
      end
      glob <= 1'b0;
      pulse(1'b0, OVF, 9'h0);
      check(32'({irq1, irq3}), 32'h0);
      glob <= 1'b1;
      repeat (2) @(posedge sys_clk);
      check(32'({irq1, irq3}), 32'h80);
      wr(8'h00, 32'h80);
      wr(8'h0c, 32'h0);
      pulse(1'b1, CAP, 9'h0);
      check(32'({irq1, irq3}), 32'h0);
      rd(8'h04, 32'h20);
      wr(8'h04, 32'h20);
      wr(8'h0c, 32'hff);
      pulse(1'b0, FA | FB, TK);
      pulse(1'b1, FA | FB, TK);
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0);
      $display("gating and force test done");
      // unit1 mode 5 counts overflow at top, unit3 mode 14 uses top for capture too
      wr(8'h10, 32'he5);
      pulse(1'b0, OVF, 9'h0);
      pulse(1'b1, CAP, 9'h0);
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0);
      pulse(1'b0, TOP, 9'h0);
      pulse(1'b1, TOP, 9'h0);
      rd(8'h00, 32'h80);
      rd(8'h04, 32'h24);
      // unit1 mode 1 and unit3 mode 8 count overflow at bottom
      wr(8'h00, 32'h80);
      wr(8'h04, 32'h24);
      wr(8'h10, 32'h81);
      pulse(1'b0, BOT, 9'h0);
      pulse(1'b1, BOT, 9'h0);
      rd(8'h00, 32'h80);
      rd(8'h04, 32'h04);
      wr(8'h10, 32'h0);
      fork
         wr(8'h00, 32'h80);
         begin
            @(posedge sys_clk);
            ev1 <= OVF;
            @(posedge sys_clk);
            ev1 <= '0;
         end
      join
      rd(8'h00, 32'h80);
      $display("mode and set-wins test done");
      run <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         lat <= k ? 4'h5 : 4'h0;
         ev1 <= OVF | CAP | MA | MB;
         ev3 <= OVF | CAP | MA | MB;
         @(posedge sys_clk);
         ev1 <= TK;
         ev3 <= TK;
         @(posedge sys_clk);
         ev1 <= '0;
         ev3 <= '0;
         repeat (120) @(posedge sys_clk);
         rd(8'h00, 32'h0);
         rd(8'h04, 32'h0);
      end
      $display("acknowledge test done");
      run <= 1'b0;
      pulse(1'b0, OVF, 9'h0);
      wr(8'h10, 32'h33);
      nrst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      check(32'({irq1, irq3}), 32'h0);
      for (int k = 0; k < 8; k++) begin
         rd(8'(k * 4), (k == 5) ? 32'h1 : 32'h0);
      end
      $display("reset test done");
      give_verdict();
   end
   initial begin
      #100000;
      n_mismatch++;
      give_verdict();
   end
endmodule
bind tif_top tif_props u_props (.sys_clk_i, .nrst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
   .hwdata_i, .hready_i, .hreadyout_o, .hresp_o, .unit1_ev_i, .unit3_ev_i, .unit1_ack_i,
   .global_irq_enable_i, .unit1_irq_o, .unit3_irq_o);
